//--- src/dpa_host.sv
// host controller driving one port of an asynchronous dual-port ram
// assumes busy and interrupt pins come straight from the ram, unclocked
`timescale 1ns/10ps
module dpa_host #(
    parameter int ADDR_W = dpa_pkg::ADDR_W,
    parameter int DATA_W = dpa_pkg::DATA_W,
    parameter bit IS_LEFT = 1'b1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire dpa_pkg::dpa_cmd_t cmd_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic slave_i,
    output logic ready_o,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic busy_seen_o,
    output logic irq_o,
    output logic chip_enable_n_o,
    output logic token_latch_select_n_o,
    output logic output_enable_n_o,
    output logic write_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic busy_n_i,
    input wire logic int_n_i
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DPA_IDLE,
        DPA_SETUP,
        DPA_STROBE,
        DPA_REST
    } dpa_state_t;

    typedef struct packed {
        dpa_state_t st;
        logic [3:0] cnt;
        dpa_pkg::dpa_cmd_t cmd;
        logic [2:0] sync_busy;
        logic [1:0] sync_int;
        logic [DATA_W-1:0] sync_data0;
        logic [DATA_W-1:0] sync_data1;
        logic ready;
        logic done;
        logic [DATA_W-1:0] rdata;
        logic busy_seen;
        logic irq;
        logic ce_n;
        logic sel_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic doe;
        logic rest_pend;
    } dpa_s_t;

    dpa_s_t s;
    dpa_s_t next_s;

    localparam logic [3:0] CNT_ONE = dpa_pkg::CNT_W1;

    function automatic logic is_read(input dpa_pkg::dpa_cmd_t c);
        return c == dpa_pkg::DPA_CMD_READ || c == dpa_pkg::DPA_CMD_TOKEN_READ;
    endfunction

    function automatic logic is_token(input dpa_pkg::dpa_cmd_t c);
        return c == dpa_pkg::DPA_CMD_TOKEN_READ ||
               c == dpa_pkg::DPA_CMD_TOKEN_WRITE;
    endfunction

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.sync_busy = {s.sync_busy[1:0], ~busy_n_i};
        next_s.sync_int = {s.sync_int[0], ~int_n_i};
        next_s.sync_data0 = data_i;
        next_s.sync_data1 = s.sync_data0;
        next_s.irq = s.sync_int[1];
        next_s.busy_seen = s.sync_busy[2];
        case (s.st)
            DPA_IDLE:
            begin
                if (req_i && s.ready)
                begin
                    next_s.ready = 1'b0;
                    next_s.cmd = cmd_i;
                    next_s.we_n = 1'b1;
                    if (is_token(cmd_i))
                        // token address uses the low three bits only
                        next_s.addr = {{(ADDR_W-dpa_pkg::TOKEN_ADDR_W){1'b0}},
                            addr_i[dpa_pkg::TOKEN_ADDR_W-1:0]};
                    else
                        next_s.addr = addr_i;
                    // only bit zero matters for token writes
                    next_s.wdata = is_token(cmd_i) ?
                        {DATA_W{wdata_i[0]}} : wdata_i;
                    next_s.doe = ~is_read(cmd_i);
                    // wait also covers the busy synchroniser depth
                    next_s.cnt = 4'(dpa_pkg::BUSY_SETTLE_CYC +
                        dpa_pkg::FLOW_CYC + $bits(s.sync_busy));
                    next_s.st = DPA_SETUP;
                end
            end
            DPA_SETUP:
            begin
                // address stable, then select; write waits for busy only when slave_i is set
                next_s.ce_n = is_token(s.cmd);
                next_s.sel_n = ~is_token(s.cmd);
                next_s.oe_n = ~is_read(s.cmd);
                if (s.cnt > CNT_ONE)
                    next_s.cnt = s.cnt - CNT_ONE;
                else if (!(slave_i && s.sync_busy[2] && !is_read(s.cmd)))
                begin
                    next_s.we_n = is_read(s.cmd);
                    next_s.cnt = 4'(dpa_pkg::ACCESS_CYC + dpa_pkg::FLOW_CYC);
                    next_s.st = DPA_STROBE;
                end
            end
            DPA_STROBE:
            begin
                if (s.cnt > CNT_ONE)
                    next_s.cnt = s.cnt - CNT_ONE;
                else
                begin
                    if (is_read(s.cmd))
                        next_s.rdata = s.sync_data1;
                    next_s.ce_n = 1'b1;
                    next_s.sel_n = 1'b1;
                    next_s.oe_n = 1'b1;
                    next_s.we_n = 1'b1;
                    next_s.doe = 1'b0;
                    // rest after token access before any read-back
                    next_s.cnt = 4'(dpa_pkg::FLAG_PULSE_CYC);
                    next_s.st = DPA_REST;
                end
            end
            DPA_REST:
            begin
                if (s.cnt > CNT_ONE)
                    next_s.cnt = s.cnt - CNT_ONE;
                else
                begin
                    next_s.done = 1'b1;
                    next_s.ready = 1'b1;
                    next_s.st = DPA_IDLE;
                end
            end
            default:
                next_s.st = DPA_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            s <= '0;
            s.st <= DPA_IDLE;
            s.ready <= 1'b1;
            s.ce_n <= 1'b1;
            s.sel_n <= 1'b1;
            s.oe_n <= 1'b1;
            s.we_n <= 1'b1;
        end
        else
            s <= next_s;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ready_o = s.ready;
    assign done_o = s.done;
    assign rdata_o = s.rdata;
    assign busy_seen_o = s.busy_seen;
    assign irq_o = s.irq;
    assign chip_enable_n_o = s.ce_n;
    assign token_latch_select_n_o = s.sel_n;
    assign output_enable_n_o = s.oe_n;
    assign write_n_o = s.we_n;
    assign addr_o = s.addr;
    assign data_o = s.wdata;
    assign data_oe_o = s.doe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_read_strobes;
        @(posedge clk_i) disable iff (!nrst_i)
        (!s.ce_n && !s.oe_n) |-> s.we_n && !s.doe;
    endproperty
    a_read_strobes: assert property (p_read_strobes)
        else $error("memory read with write strobe or drive active");

    property p_token_sel;
        @(posedge clk_i) disable iff (!nrst_i)
        !s.sel_n |-> s.ce_n && s.addr[ADDR_W-1:dpa_pkg::TOKEN_ADDR_W] == '0;
    endproperty
    a_token_sel: assert property (p_token_sel)
        else $error("token access with chip enable or high address");

    property p_token_read;
        @(posedge clk_i) disable iff (!nrst_i)
        (!s.sel_n && s.we_n && s.st == DPA_STROBE) |-> !s.oe_n;
    endproperty
    a_token_read: assert property (p_token_read)
        else $error("token read without output enable");

    sequence s_strobe_end;
        s.st == DPA_STROBE ##1 s.st == DPA_REST;
    endsequence
    property p_rest;
        @(posedge clk_i) disable iff (!nrst_i)
        s_strobe_end |-> s.sel_n && s.oe_n;
    endproperty
    a_rest: assert property (p_rest)
        else $error("no rest after token access");

    property p_slave_wait;
        @(posedge clk_i) disable iff (!nrst_i)
        $fell(s.we_n) |-> !(slave_i && $past(s.sync_busy[2]));
    endproperty
    a_slave_wait: assert property (p_slave_wait)
        else $error("slave write started while busy");

    property p_token_bit0;
        @(posedge clk_i) disable iff (!nrst_i)
        (!s.sel_n && s.doe) |-> s.wdata == {DATA_W{s.wdata[0]}};
    endproperty
    a_token_bit0: assert property (p_token_bit0)
        else $error("token write data not from bit zero");
endmodule // dpa_host

//--- shared/dpa_pkg.sv
// constants for the host-side controller of one dual-port ram port
// assumes a 10 MHz clock and an asynchronous dual-port ram on the pins
package dpa_pkg;
    // ------------------------------------------------------------
    // memory geometry and mailbox words
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 9;
    localparam logic [ADDR_W-1:0] MBOX_RIGHT = 16'hffff;
    localparam logic [ADDR_W-1:0] MBOX_LEFT = 16'hfffe;
    localparam int TOKEN_ADDR_W = 3;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int FLAG_UPDATE_PULSE_NS = 12;
    localparam int FLOWTHROUGH_DELAY_NS = 35;
    localparam int BUSY_FROM_ENABLE_DELAY_NS = 20;
    localparam int FLAG_PULSE_CYC =
        (FLAG_UPDATE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOW_CYC =
        (FLOWTHROUGH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_SETTLE_CYC =
        (BUSY_FROM_ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // access phases: setup, strobe, hold
    localparam int ACCESS_CYC = 2;
    localparam logic [3:0] CNT_W1 = 4'h1;
    // ------------------------------------------------------------
    // commands
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DPA_CMD_READ,
        DPA_CMD_WRITE,
        DPA_CMD_TOKEN_READ,
        DPA_CMD_TOKEN_WRITE
    } dpa_cmd_t;
endpackage

//--- testbench/dpa_ram_model.sv
// behavioural dual-port ram seen from the left port, with right-port tasks
// assumes the host drives the left pins; the right port is reached by tasks
`timescale 1ns/10ps
module dpa_ram_model (
    input wire logic ce_n_i,
    input wire logic sem_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [15:0] addr_i,
    input wire logic [8:0] data_i,
    output logic [8:0] data_o,
    output logic busy_n_o,
    output logic int_n_o
);
    // ------------------------------------------------------------
    // storage: array apart from 8 token latches, owner 1 left 2 right
    // ------------------------------------------------------------
    logic [8:0] mem [65536];
    logic [1:0] own [8];
    logic pend [3][8];
    logic int_l;
    logic int_r;
    logic r_on;
    logic [15:0] r_addr;
    logic [8:0] tokq;
    logic [8:0] last;
    initial
    begin
        int_l = 1'b0;
        int_r = 1'b0;
        r_on = 1'b0;
        r_addr = 16'h0000;
        last = 9'h000;
        tokq = 9'h1ff;
        for (int i = 0; i < 8; i++)
        begin
            own[i] = 2'h0;
            pend[1][i] = 1'b0;
            pend[2][i] = 1'b0;
        end
    end
    // ------------------------------------------------------------
    // token and right-port actions
    // ------------------------------------------------------------
    task automatic token(input logic [1:0] s, input logic [2:0] i,
                         input logic b);
        logic [1:0] o;
        o = 2'h3 - s;
        if (!b && own[i] == 2'h0)
            own[i] = s;
        else if (!b && own[i] == o)
            pend[s][i] = 1'b1;
        else if (b && own[i] == s)
        begin
            own[i] = pend[o][i] ? o : 2'h0;
            pend[o][i] = 1'b0;
        end
        else if (b)
            pend[s][i] = 1'b0;
    endtask
    task automatic right_write(input logic [15:0] a, input logic [8:0] d);
        mem[a] = d;
        if (a == dpa_pkg::MBOX_LEFT)
            int_l = 1'b1;
    endtask
    task automatic right_token(input logic [2:0] i, input logic b);
        token(2'h2, i, b);
    endtask
    // right port holding an address: it came first, left loses
    task automatic right_hold(input logic [15:0] a, input logic on);
        r_addr = a;
        r_on = on;
    endtask
    // ------------------------------------------------------------
    // left port access
    // ------------------------------------------------------------
    always @(negedge we_n_i) #1
    begin
        if (!ce_n_i && busy_n_o)
        begin
            mem[addr_i] = data_i;
            if (addr_i == dpa_pkg::MBOX_RIGHT)
                int_r = 1'b1;
        end
        else if (!sem_n_i)
            token(2'h1, addr_i[2:0], data_i[0]);
    end
    always @(negedge oe_n_i) #1
    begin
        if (!sem_n_i && ce_n_i)
            tokq = {9{own[addr_i[2:0]] != 2'h1}};
        if (!ce_n_i && busy_n_o && addr_i == dpa_pkg::MBOX_LEFT)
            int_l = 1'b0;
        #1 last = data_o;
    end
    // released bus shows the inverse of the last value
    assign data_o = (!oe_n_i && we_n_i && !ce_n_i) ? mem[addr_i] :
        (!oe_n_i && we_n_i && !sem_n_i) ? tokq : ~last;
    // master: busy to the left while the right port holds the address
    assign busy_n_o = ~(r_on && !ce_n_i && addr_i == r_addr);
    assign int_n_o = ~int_l;
endmodule // dpa_ram_model

//--- testbench/dual_port_ram_arbitration_test.sv
// self-checking bench for the host port controller
// assumes dpa_ram_model stands on the pins as a master device
`timescale 1ns/10ps
module dual_port_ram_arbitration_test;
    logic clk_i = 1'b0, nrst_i = 1'b0, req_i = 1'b0, slave_i = 1'b0;
    dpa_pkg::dpa_cmd_t cmd_i = dpa_pkg::DPA_CMD_READ;
    logic [15:0] addr_i = 16'h0000, addr_o;
    logic [8:0] wdata_i = 9'h000, rdata_o, data_o, data_i;
    logic ready_o, done_o, busy_seen_o, irq_o, ce_n, sem_n, oe_n, we_n;
    logic data_oe_o, busy_n, int_n;
    int failures = 0, num_checks = 0, cycles = 0;
    dpa_host uut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i),
        .cmd_i(cmd_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .slave_i(slave_i), .ready_o(ready_o), .done_o(done_o),
        .rdata_o(rdata_o), .busy_seen_o(busy_seen_o), .irq_o(irq_o),
        .chip_enable_n_o(ce_n), .token_latch_select_n_o(sem_n),
        .output_enable_n_o(oe_n), .write_n_o(we_n), .addr_o(addr_o),
        .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i),
        .busy_n_i(busy_n), .int_n_i(int_n));
    dpa_ram_model dev (.ce_n_i(ce_n), .sem_n_i(sem_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .addr_i(addr_o), .data_i(data_o),
        .data_o(data_i), .busy_n_o(busy_n), .int_n_o(int_n));
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [8:0] e,
                       input logic [8:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic op(input dpa_pkg::dpa_cmd_t c, input logic [15:0] a,
                      input logic [8:0] d);
        int n;
        n = 0;
        chk("ready", 9'h001, {8'h00, ready_o});
        cmd_i = c;
        addr_i = a;
        wdata_i = d;
        req_i = 1'b1;
        @(posedge clk_i);
        #10 req_i = 1'b0;
        while (done_o !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            #10 n++;
        end
        chk("done", 9'h001, {8'h00, done_o});
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk_i);
        #10;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_mem;
        op(dpa_pkg::DPA_CMD_WRITE, 16'h1234, 9'h15a);
        op(dpa_pkg::DPA_CMD_READ, 16'h1234, 9'h000);
        chk("mem", 9'h15a, rdata_o);
        dev.right_write(16'h2000, 9'h0f0);
        op(dpa_pkg::DPA_CMD_READ, 16'h2000, 9'h000);
        chk("flowthrough", 9'h0f0, rdata_o);
    endtask
    task automatic t_busy;
        dev.right_write(dpa_pkg::MBOX_LEFT, 9'h011);
        dev.right_hold(dpa_pkg::MBOX_LEFT, 1'b1);
        op(dpa_pkg::DPA_CMD_READ, dpa_pkg::MBOX_LEFT, 9'h000);
        chk("busy seen", 9'h001, {8'h00, busy_seen_o});
        wait_cyc(3);
        chk("irq held", 9'h001, {8'h00, irq_o});
        dev.right_hold(dpa_pkg::MBOX_RIGHT, 1'b1);
        op(dpa_pkg::DPA_CMD_WRITE, dpa_pkg::MBOX_RIGHT, 9'h022);
        chk("irq right held", 9'h000, {8'h00, dev.int_r});
        dev.right_hold(dpa_pkg::MBOX_RIGHT, 1'b0);
        op(dpa_pkg::DPA_CMD_WRITE, dpa_pkg::MBOX_RIGHT, 9'h022);
        chk("irq right", 9'h001, {8'h00, dev.int_r});
        slave_i = 1'b1;
        dev.right_hold(16'h0040, 1'b1);
        fork
            op(dpa_pkg::DPA_CMD_WRITE, 16'h0040, 9'h0a5);
            begin
                wait_cyc(10);
                chk("slave wait", 9'h001, {8'h00, we_n});
                chk("data drive", 9'h001, {8'h00, data_oe_o});
                chk("busy held", 9'h001, {8'h00, busy_seen_o});
                dev.right_hold(16'h0040, 1'b0);
            end
        join
        op(dpa_pkg::DPA_CMD_READ, 16'h0040, 9'h000);
        chk("slave write", 9'h0a5, rdata_o);
        slave_i = 1'b0;
    endtask
    task automatic t_mbox;
        dev.right_write(dpa_pkg::MBOX_LEFT, 9'h0c3);
        wait_cyc(4);
        chk("irq set", 9'h001, {8'h00, irq_o});
        op(dpa_pkg::DPA_CMD_READ, dpa_pkg::MBOX_RIGHT, 9'h000);
        wait_cyc(3);
        chk("irq kept", 9'h001, {8'h00, irq_o});
        op(dpa_pkg::DPA_CMD_READ, dpa_pkg::MBOX_LEFT, 9'h000);
        chk("mailbox", 9'h0c3, rdata_o);
        wait_cyc(3);
        chk("irq clear", 9'h000, {8'h00, irq_o});
    endtask
    task automatic t_token;
        for (int i = 0; i < 8; i++)
        begin
            op(dpa_pkg::DPA_CMD_TOKEN_READ, 16'(i), 9'h000);
            chk("token free", 9'h1ff, rdata_o);
        end
        op(dpa_pkg::DPA_CMD_TOKEN_WRITE, 16'hab3, 9'h000);
        op(dpa_pkg::DPA_CMD_TOKEN_READ, 16'h0003, 9'h000);
        chk("token won", 9'h000, rdata_o);
        op(dpa_pkg::DPA_CMD_TOKEN_READ, 16'h0005, 9'h000);
        chk("other token", 9'h1ff, rdata_o);
        dev.right_token(3'h3, 1'b0);
        op(dpa_pkg::DPA_CMD_TOKEN_READ, 16'h0003, 9'h000);
        chk("token held", 9'h000, rdata_o);
        op(dpa_pkg::DPA_CMD_TOKEN_WRITE, 16'h0003, 9'h1fe);
        op(dpa_pkg::DPA_CMD_TOKEN_READ, 16'h0003, 9'h000);
        chk("token kept", 9'h000, rdata_o);
        op(dpa_pkg::DPA_CMD_TOKEN_WRITE, 16'h0003, 9'h001);
        op(dpa_pkg::DPA_CMD_TOKEN_READ, 16'h0003, 9'h000);
        chk("token passed", 9'h1ff, rdata_o);
    endtask
    // ------------------------------------------------------------
    // sequence and timeout
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        #10 nrst_i = 1'b1;
        wait_cyc(1);
        t_mem;
        t_mbox;
        t_busy;
        t_token;
        tally_and_finish;
    end
endmodule // dual_port_ram_arbitration_test
